/* hdl/dcd_pkg.sv */
// Shared constants for the 16-bit DSP core datapath.
// Assumes a single clock domain; one instruction per cycle except in the stall, repeat and interrupt states.
package dcd_pkg;
    localparam int INSTR_W      = 24;
    localparam int PC_W         = 23;
    localparam int DATA_W       = 16;
    localparam int NUM_REGS     = 16;
    localparam int REG_IDX_W    = 4;
    localparam int SP_IDX       = 15;
    localparam int DADDR_W      = 16;
    localparam int ACC_W        = 40;
    localparam int MUL_W        = 17;
    localparam int SHIFT_MAX    = 16;
    localparam int SHIFT_W      = 6;
    localparam int PAGE_W       = 8;
    localparam int PSV_OFF_W    = 15;
    localparam int DIV_CYCLES   = 19;
    localparam int CNT_W        = 14;
    localparam logic [PC_W-1:0]    PC_STEP      = 23'h000002;
    localparam logic [PC_W-1:0]    PC_RESET     = 23'h000000;
    localparam logic [DADDR_W-1:0] Y_BASE_DEF   = 16'h1800;
    localparam logic [DADDR_W-1:0] PSV_BASE     = 16'h8000;
    localparam logic [DADDR_W-1:0] ADDR_STEP    = 16'h0002;
    localparam logic [ACC_W-1:0]   ACC_POS_MAX  = 40'h7FFFFFFFFF;
    localparam logic [ACC_W-1:0]   ACC_NEG_MAX  = 40'h8000000000;

    typedef enum logic [3:0] {
        DCD_OP_NOP   = 4'h0,
        DCD_OP_ADD   = 4'h1,
        DCD_OP_SUB   = 4'h2,
        DCD_OP_AND   = 4'h3,
        DCD_OP_MOVI  = 4'h4,
        DCD_OP_LOAD  = 4'h5,
        DCD_OP_STORE = 4'h6,
        DCD_OP_MAC   = 4'h7,
        DCD_OP_SFTAC = 4'h8,
        DCD_OP_BRA   = 4'h9,
        DCD_OP_DMOV  = 4'hA,
        DCD_OP_TBL   = 4'hB,
        DCD_OP_REPT  = 4'hC,
        DCD_OP_DOLP  = 4'hD,
        DCD_OP_DIV   = 4'hE,
        DCD_OP_CALL  = 4'hF
    } dcd_op_t;

    typedef enum logic [3:0] {
        DCD_ST_RUN   = 4'b0001,
        DCD_ST_STALL = 4'b0010,
        DCD_ST_REPT  = 4'b0100,
        DCD_ST_IRQ   = 4'b1000
    } dcd_state_t;
endpackage

/* hdl/dcd_core.sv */
// Datapath of a 16-bit DSP core: fetch, register file, X/Y address units, DSP engine.
// Assumes program memory answers the fetch address in the same cycle and
// data memory reads return combinationally; interrupts arrive as a level.
`timescale 1ns/100ps
`default_nettype none
module dcd_core #(
    parameter logic [15:0] Y_BASE = dcd_pkg::Y_BASE_DEF     // X/Y boundary
) (
    input  wire logic        clk,            // Core clock
    input  wire logic        nrst,           // Async reset, active low
    input  wire logic [23:0] instr_word,     // Fetched instruction
    input  wire logic        irq,            // Interrupt request level
    input  wire logic [15:0] x_rdata,        // X bus read data
    input  wire logic [15:0] y_rdata,        // Y bus read data
    input  wire logic [23:0] psv_rdata,      // Program data via window
    input  wire logic        psv_enable,     // Window enable
    input  wire logic        sat_enable,     // Accumulator saturation enable
    input  wire logic [15:0] mod_start,      // Modulo buffer start
    input  wire logic [15:0] mod_end,        // Modulo buffer end
    input  wire logic        mod_enable,     // Modulo addressing enable
    input  wire logic        bitrev_enable,  // Bit-reversed X addressing
    input  wire logic [15:0] bitrev_mod,     // Bit-reverse modifier
    input  wire logic [7:0]  page_value,     // Program window page
    input  wire logic        page_load,      // Load page register
    output logic [22:0]      program_counter,   // Fetch address
    output logic [15:0]      x_addr,         // X data address
    output logic [15:0]      y_addr,         // Y data address
    output logic             y_rd,           // Y read strobe
    output logic [15:0]      x_wdata,        // X write data
    output logic             x_wr,           // X write strobe
    output logic [22:0]      psv_addr,       // Program window address
    output logic [15:0]      stack_pointer_reg, // Stack pointer copy
    output logic [39:0]      acc_a,          // Accumulator A
    output logic [39:0]      acc_b,          // Accumulator B
    output logic             repeat_active,  // Repeat loop running
    output logic             irq_taken       // Interrupt vector pulse
);
    localparam int AW = dcd_pkg::ACC_W;

    logic [23:0] exec_word;
    logic [15:0] wreg [dcd_pkg::NUM_REGS];
    logic [7:0]  program_window_page;
    logic [13:0] rep_cnt;
    dcd_pkg::dcd_state_t state;
    dcd_pkg::dcd_op_t    op;
    logic [3:0]  rd, rs, rt;
    logic [15:0] imm, rs_v, rt_v, ea, lin_addr, next_xea, next_yea;
    logic [39:0] sum_ext, sat_sum, shifted;
    logic signed [16:0] m_a, m_b;
    logic signed [33:0] product;
    logic        multi, in_psv, stall_done;
    logic [22:0] next_pc;
    logic [15:0] rev_ptr, rev_step, rev_sum, rev_next;

    // Fixed 24-bit opcode: top nibble selects the class, rest is operands
    // decode fields
    assign op   = dcd_pkg::dcd_op_t'(exec_word[23:20]);
    assign rd   = exec_word[19:16];
    assign rs   = exec_word[15:12];
    assign rt   = exec_word[11:8];
    assign imm  = exec_word[15:0];
    assign rs_v = wreg[rs];
    assign rt_v = wreg[rt];
    assign ea   = rs_v + {8'h00, exec_word[7:0]};

    assign multi = (op == dcd_pkg::DCD_OP_BRA) || (op == dcd_pkg::DCD_OP_DMOV)
                || (op == dcd_pkg::DCD_OP_TBL) || (op == dcd_pkg::DCD_OP_CALL);
    assign stall_done = (state == dcd_pkg::DCD_ST_STALL);

    // modulo wrap, bit-reverse only on X
    always_comb
    begin
        // Reverse-carry add: flip, add, flip back
        for (int i = 0; i < dcd_pkg::DATA_W; i++)
        begin
            rev_ptr[i]  = rs_v[dcd_pkg::DATA_W - 1 - i];
            rev_step[i] = bitrev_mod[dcd_pkg::DATA_W - 1 - i];
        end
        rev_sum = rev_ptr + rev_step;
        for (int i = 0; i < dcd_pkg::DATA_W; i++)
            rev_next[i] = rev_sum[dcd_pkg::DATA_W - 1 - i];
        next_xea = rs_v + dcd_pkg::ADDR_STEP;
        if (bitrev_enable)
            next_xea = rev_next;
        else if (mod_enable && rs_v == mod_end)
            next_xea = mod_start;
        next_yea = rt_v + dcd_pkg::ADDR_STEP;
        if (mod_enable && rt_v == mod_end)
            next_yea = mod_start;
    end

    // linear X, program window in upper half
    assign lin_addr = (op == dcd_pkg::DCD_OP_LOAD || op == dcd_pkg::DCD_OP_STORE) ? ea : rs_v;
    assign in_psv   = psv_enable && lin_addr[15];

    // 17x17 signed multiply of sign-extended operands
    assign m_a     = {rs_v[15], rs_v};
    assign m_b     = {rt_v[15], rt_v};
    assign product = m_a * m_b;
    // accumulate into A or B chosen by rd[0]
    assign sum_ext = (rd[0] ? acc_b : acc_a) + {{6{product[33]}}, product};
    always_comb
    begin
        sat_sum = sum_ext;
        if (sat_enable && !sum_ext[AW-1] && (rd[0] ? acc_b[AW-1] : acc_a[AW-1]) && product[33])
            sat_sum = dcd_pkg::ACC_NEG_MAX;
        else if (sat_enable && sum_ext[AW-1] && !(rd[0] ? acc_b[AW-1] : acc_a[AW-1])
                 && !product[33])
            sat_sum = dcd_pkg::ACC_POS_MAX;
    end

    // signed amount in imm[5:0]; beyond 16 either way, no shift
    always_comb
    begin
        shifted = rd[0] ? acc_b : acc_a;
        if (!imm[5] && imm[4:0] <= 5'(dcd_pkg::SHIFT_MAX))
            shifted = shifted << imm[4:0];
        else if (imm[5] && (6'h00 - imm[5:0]) <= 6'(dcd_pkg::SHIFT_MAX))
            shifted = $signed(shifted) >>> (6'h00 - imm[5:0]);
    end

    // 23-bit counter; prefetch latches next word
    always_comb
    begin
        next_pc = program_counter + dcd_pkg::PC_STEP;
        if ((op == dcd_pkg::DCD_OP_BRA || op == dcd_pkg::DCD_OP_CALL) && stall_done)
            next_pc = program_counter + {{7{imm[15]}}, imm};
    end

    // state machine: stall, repeat, interrupt suspend
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state <= dcd_pkg::DCD_ST_RUN;
        else
            case (state)
                dcd_pkg::DCD_ST_RUN:
                    if (irq)
                        state <= dcd_pkg::DCD_ST_IRQ;
                    else if (multi)
                        state <= dcd_pkg::DCD_ST_STALL;
                    else if (op == dcd_pkg::DCD_OP_REPT || op == dcd_pkg::DCD_OP_DIV)
                        state <= dcd_pkg::DCD_ST_REPT;
                dcd_pkg::DCD_ST_STALL:
                    state <= dcd_pkg::DCD_ST_RUN;
                dcd_pkg::DCD_ST_REPT:
                    if (irq)
                        state <= dcd_pkg::DCD_ST_IRQ;
                    else if (rep_cnt == 14'h0000)
                        state <= dcd_pkg::DCD_ST_RUN;
                dcd_pkg::DCD_ST_IRQ:
                    state <= (rep_cnt != 14'h0000) ? dcd_pkg::DCD_ST_REPT : dcd_pkg::DCD_ST_RUN;
                default:
                    state <= dcd_pkg::DCD_ST_RUN;
            endcase
    end

    // divide loads 19-cycle count; counter kept across interrupt
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rep_cnt <= 14'h0000;
        else if (state == dcd_pkg::DCD_ST_RUN && !irq && op == dcd_pkg::DCD_OP_DIV)
            rep_cnt <= 14'(dcd_pkg::DIV_CYCLES - 2);
        else if (state == dcd_pkg::DCD_ST_RUN && !irq && op == dcd_pkg::DCD_OP_REPT)
            rep_cnt <= imm[13:0];
        else if (state == dcd_pkg::DCD_ST_REPT && !irq && rep_cnt != 14'h0000)
            rep_cnt <= rep_cnt - 14'h0001;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            program_counter <= dcd_pkg::PC_RESET;
            exec_word       <= 24'h000000;
        end
        else if (state == dcd_pkg::DCD_ST_IRQ)
        begin
            program_counter <= program_counter;
            exec_word       <= exec_word;
        end
        else if ((state == dcd_pkg::DCD_ST_RUN && (multi || irq))
                 || (state == dcd_pkg::DCD_ST_REPT && rep_cnt != 14'h0000))
        begin
            // Hold the fetch while the current word needs more cycles
            program_counter <= program_counter;
            exec_word       <= exec_word;
        end
        else
        begin
            program_counter <= next_pc;
            // Flow change discards the prefetched word
            exec_word <= (stall_done && op != dcd_pkg::DCD_OP_DMOV
                          && op != dcd_pkg::DCD_OP_TBL) ? 24'h000000 : instr_word;
        end
    end

    // general register file; stack pushes on call/interrupt
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < dcd_pkg::NUM_REGS; i++)
                wreg[i] <= 16'h0000;
        end
        else if (state == dcd_pkg::DCD_ST_IRQ
                 || (stall_done && op == dcd_pkg::DCD_OP_CALL))
            wreg[dcd_pkg::SP_IDX] <= wreg[dcd_pkg::SP_IDX] + dcd_pkg::ADDR_STEP;
        else if (state == dcd_pkg::DCD_ST_RUN && !irq)
            case (op)
                dcd_pkg::DCD_OP_ADD:   wreg[rd] <= rs_v + rt_v;
                dcd_pkg::DCD_OP_SUB:   wreg[rd] <= rs_v - rt_v;
                dcd_pkg::DCD_OP_AND:   wreg[rd] <= rs_v & rt_v;
                dcd_pkg::DCD_OP_MOVI:  wreg[rd] <= imm;
                dcd_pkg::DCD_OP_LOAD:
                    wreg[rd] <= in_psv ? psv_rdata[15:0] : x_rdata;
                // rs walks X, rt walks Y
                dcd_pkg::DCD_OP_MAC:
                begin
                    wreg[rs] <= next_xea;
                    wreg[rt] <= next_yea;
                end
                default: ;
            endcase
        else if (stall_done && op == dcd_pkg::DCD_OP_DMOV)
        begin
            wreg[rd]               <= x_rdata;
            wreg[rd ^ 4'h1]        <= y_rdata;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_a <= 40'h0000000000;
            acc_b <= 40'h0000000000;
        end
        else if ((state == dcd_pkg::DCD_ST_RUN && !irq && op == dcd_pkg::DCD_OP_MAC)
                 || (state == dcd_pkg::DCD_ST_REPT && !irq))
        begin
            if (rd[0])
                acc_b <= sat_sum;
            else
                acc_a <= sat_sum;
        end
        else if (state == dcd_pkg::DCD_ST_RUN && !irq && op == dcd_pkg::DCD_OP_SFTAC)
        begin
            if (rd[0])
                acc_b <= shifted;
            else
                acc_a <= shifted;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            program_window_page <= 8'h00;
        else if (page_load)
            program_window_page <= page_value;
    end

    // read, write and fetch share the cycle; X/Y split
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            x_addr   <= 16'h0000;
            y_addr   <= Y_BASE;
            y_rd     <= 1'b0;
            x_wdata  <= 16'h0000;
            x_wr     <= 1'b0;
            psv_addr <= 23'h000000;
        end
        else
        begin
            x_addr  <= lin_addr;
            // Y pointer forced into Y block
            y_addr  <= (rt_v < Y_BASE) ? Y_BASE : rt_v;
            y_rd    <= (state == dcd_pkg::DCD_ST_RUN) && (op == dcd_pkg::DCD_OP_MAC);
            x_wdata <= wreg[rd];
            x_wr    <= (state == dcd_pkg::DCD_ST_RUN) && !irq && (op == dcd_pkg::DCD_OP_STORE);
            psv_addr <= {program_window_page, lin_addr[dcd_pkg::PSV_OFF_W-1:0]};
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stack_pointer_reg <= 16'h0000;
            repeat_active     <= 1'b0;
            irq_taken         <= 1'b0;
        end
        else
        begin
            stack_pointer_reg <= wreg[dcd_pkg::SP_IDX];
            repeat_active     <= (state == dcd_pkg::DCD_ST_REPT);
            irq_taken         <= (state != dcd_pkg::DCD_ST_IRQ) && irq
                                 && (state != dcd_pkg::DCD_ST_STALL);
        end
    end

    // divide still in repeat eight cycles after it starts
    a_div_length: assert property (@(posedge clk) disable iff (!nrst)
        (state == dcd_pkg::DCD_ST_RUN && !irq && op == dcd_pkg::DCD_OP_DIV)
        ##1 (!irq)[*8] |-> state == dcd_pkg::DCD_ST_REPT)
        else $error("divide left repeat early");
    a_stall_once: assert property (@(posedge clk) disable iff (!nrst)
        state == dcd_pkg::DCD_ST_STALL |=> state == dcd_pkg::DCD_ST_RUN)
        else $error("stall lasted over one cycle");
    a_irq_suspend: assert property (@(posedge clk) disable iff (!nrst)
        (state == dcd_pkg::DCD_ST_REPT && irq) |=> state == dcd_pkg::DCD_ST_IRQ)
        else $error("loop not suspended");
    a_pc_step: assert property (@(posedge clk) disable iff (!nrst)
        (state == dcd_pkg::DCD_ST_RUN && !irq && !multi && op != dcd_pkg::DCD_OP_REPT
         && op != dcd_pkg::DCD_OP_DIV) |=> program_counter == $past(program_counter)
         + dcd_pkg::PC_STEP)
        else $error("prefetch did not advance");
    a_sp_push: assert property (@(posedge clk) disable iff (!nrst)
        state == dcd_pkg::DCD_ST_IRQ |=> ##1 stack_pointer_reg
        == $past(stack_pointer_reg) + dcd_pkg::ADDR_STEP)
        else $error("stack pointer not pushed");
    a_y_block: assert property (@(posedge clk) disable iff (!nrst)
        y_addr >= Y_BASE)
        else $error("Y address below boundary");
    a_store_write: assert property (@(posedge clk) disable iff (!nrst)
        (state == dcd_pkg::DCD_ST_RUN && !irq && op == dcd_pkg::DCD_OP_STORE)
        |=> x_wr && x_addr == $past(ea))
        else $error("store strobe missing");
    a_sat_clamp: assert property (@(posedge clk) disable iff (!nrst)
        (sat_enable && state == dcd_pkg::DCD_ST_RUN && !irq && op == dcd_pkg::DCD_OP_MAC
         && !rd[0] && !acc_a[39] && !product[33] && sum_ext[39])
        |=> acc_a == dcd_pkg::ACC_POS_MAX)
        else $error("saturation failed");
endmodule
`default_nettype wire

/* bench/dsp_cpu_core_datapath_tb_top.sv */
// Self-checking bench for the DSP core datapath: short programs, reset between them.
// Assumes program and data memories answer combinationally, as the core expects.
`timescale 1ns/100ps
`default_nettype none
module dsp_cpu_core_datapath_tb_top;
    logic        clk;
    logic        nrst;
    logic [23:0] instr_word;
    logic        irq;
    logic [15:0] x_rdata;
    logic [15:0] y_rdata;
    logic [23:0] psv_rdata;
    logic        psv_enable;
    logic        sat_enable;
    logic [15:0] mod_start;
    logic [15:0] mod_end;
    logic        mod_enable;
    logic        bitrev_enable;
    logic [15:0] bitrev_mod;
    logic [7:0]  page_value;
    logic        page_load;
    logic [22:0] program_counter;
    logic [15:0] x_addr;
    logic [15:0] y_addr;
    logic        y_rd;
    logic [15:0] x_wdata;
    logic        x_wr;
    logic [22:0] psv_addr;
    logic [15:0] stack_pointer_reg;
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    logic        repeat_active;
    logic        irq_taken;
    logic [23:0] prog [0:63];
    int          errors;
    int          num_checks;
    int          seed;
    int          stalls;
    int          wr_cnt;
    int          irq_cnt;
    int          yrd_cnt;
    int          rep_after;
    int          psv_hit;
    logic [15:0] wr_data;
    logic [15:0] wr_addr;
    logic [22:0] pc_start;
    logic [22:0] pc_end;
    logic [22:0] psv_exp;
    logic [15:0] va;
    logic [15:0] vb;
    logic [7:0]  pg;
    logic [39:0] prod;
    logic [39:0] prod_b;
    int          exp_stall[$];
    dcd_pkg::dcd_op_t ops[$];

    // Memories reply in the same cycle; data depends on the address so it is never stale
    assign instr_word = prog[program_counter[6:1]];
    assign x_rdata    = x_addr ^ 16'h5A5A;
    assign y_rdata    = y_addr ^ 16'hA5A5;
    assign psv_rdata  = {1'b0, psv_addr};

    dcd_core #(
        .Y_BASE (dcd_pkg::Y_BASE_DEF)
    ) uut (
        .clk               (clk),
        .nrst              (nrst),
        .instr_word        (instr_word),
        .irq               (irq),
        .x_rdata           (x_rdata),
        .y_rdata           (y_rdata),
        .psv_rdata         (psv_rdata),
        .psv_enable        (psv_enable),
        .sat_enable        (sat_enable),
        .mod_start         (mod_start),
        .mod_end           (mod_end),
        .mod_enable        (mod_enable),
        .bitrev_enable     (bitrev_enable),
        .bitrev_mod        (bitrev_mod),
        .page_value        (page_value),
        .page_load         (page_load),
        .program_counter   (program_counter),
        .x_addr            (x_addr),
        .y_addr            (y_addr),
        .y_rd              (y_rd),
        .x_wdata           (x_wdata),
        .x_wr              (x_wr),
        .psv_addr          (psv_addr),
        .stack_pointer_reg (stack_pointer_reg),
        .acc_a             (acc_a),
        .acc_b             (acc_b),
        .repeat_active     (repeat_active),
        .irq_taken         (irq_taken)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [23:0] mk(input dcd_pkg::dcd_op_t op, input logic [3:0] rd,
                                       input logic [15:0] lo);
        return {op, rd, lo};
    endfunction

    // Bit-reversed step: the carry runs from the top bit down
    function automatic logic [15:0] rev_add(input logic [15:0] a, input logic [15:0] b);
        logic        c;
        logic [15:0] s;
        c = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            s[i] = a[i] ^ b[i] ^ c;
            c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
        end
        return s;
    endfunction

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Reset is raised before the program is swapped so the old one never runs on
    task automatic begin_reset();
        @(posedge clk);
        nrst <= 1'b0;
        for (int i = 0; i < 64; i++)
            prog[i] = 24'h000000;
    endtask

    task automatic end_reset();
        repeat (11) @(posedge clk);
        @(negedge clk);
        chk(program_counter, 40'h0, "pc in reset");
        chk(acc_a, 40'h0, "acc in reset");
        chk(y_addr, dcd_pkg::Y_BASE_DEF, "y boundary");
        @(posedge clk);
        nrst <= 1'b1;
    endtask

    // Samples settled outputs at falling edges and tallies what happened
    task automatic watch(input int n);
        logic [22:0] prev;
        stalls = 0;
        wr_cnt = 0;
        irq_cnt = 0;
        yrd_cnt = 0;
        rep_after = 0;
        psv_hit = 0;
        @(negedge clk);
        prev = program_counter;
        pc_start = program_counter;
        repeat (n)
        begin
            @(negedge clk);
            if (program_counter === prev)
                stalls++;
            prev = program_counter;
            if (x_wr === 1'b1)
            begin
                wr_cnt++;
                wr_data = x_wdata;
                wr_addr = x_addr;
            end
            if (irq_taken === 1'b1)
                irq_cnt++;
            else if (irq_cnt > 0 && repeat_active === 1'b1)
                rep_after = 1;
            if (y_rd === 1'b1)
                yrd_cnt++;
            if (psv_addr === psv_exp)
                psv_hit = 1;
        end
        pc_end = program_counter;
    endtask

    initial
    begin
        #20000;
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end

    initial
    begin
        errors = 0;
        num_checks = 0;
        seed = 32'h941265ff;
        nrst = 1'b0;
        irq = 1'b0;
        psv_enable = 1'b1;
        sat_enable = 1'b1;
        mod_start = 16'($random(seed));
        mod_end = 16'($random(seed));
        mod_enable = 1'b0;
        bitrev_enable = 1'b0;
        bitrev_mod = 16'($random(seed));
        page_value = 8'h00;
        page_load = 1'b0;
        psv_exp = 23'h7FFFFF;

        begin_reset();
        end_reset();
        watch(10);
        chk(pc_end - pc_start, 40'd20, "pc step");
        chk(stalls, 40'd0, "nop stalls");

        ops = '{dcd_pkg::DCD_OP_DMOV, dcd_pkg::DCD_OP_TBL, dcd_pkg::DCD_OP_DIV};
        // Divide word and the step it repeats fill 19 cycles; two are normal slots
        exp_stall = '{1, 1, dcd_pkg::DIV_CYCLES - 2};
        foreach (ops[i])
        begin
            begin_reset();
            prog[0] = mk(dcd_pkg::DCD_OP_MOVI, 4'h3, 16'h0007);
            prog[1] = mk(ops[i], 4'h1, 16'h2300);
            end_reset();
            watch(30);
            chk(stalls, exp_stall[i], "multi-cycle stalls");
        end

        va = 16'($random(seed)) & 16'h7FFE;
        begin_reset();
        prog[0] = mk(dcd_pkg::DCD_OP_MOVI, 4'h5, va);
        prog[1] = mk(dcd_pkg::DCD_OP_STORE, 4'h5, 16'h5000);
        end_reset();
        watch(10);
        chk(wr_cnt, 40'd1, "store count");
        chk(wr_data, va, "store data");
        chk(wr_addr, va, "store pointer");

        va = 16'($random(seed));
        vb = 16'($random(seed));
        begin_reset();
        prog[0] = mk(dcd_pkg::DCD_OP_MOVI, 4'h1, va);
        prog[1] = mk(dcd_pkg::DCD_OP_MOVI, 4'h2, vb);
        prog[2] = mk(dcd_pkg::DCD_OP_ADD, 4'h3, 16'h1200);
        prog[3] = mk(dcd_pkg::DCD_OP_STORE, 4'h3, 16'h3000);
        end_reset();
        watch(12);
        chk(wr_data, 16'(va + vb), "sum stored");

        va = 16'($random(seed)) & 16'h7FFE;
        begin_reset();
        prog[0] = mk(dcd_pkg::DCD_OP_MOVI, 4'hF, va);
        prog[1] = mk(dcd_pkg::DCD_OP_REPT, 4'h0, 16'h000A);
        end_reset();
        fork
            watch(40);
            begin
                repeat (6) @(posedge clk);
                irq <= 1'b1;
                for (int i = 0; i < 20 && irq_taken !== 1'b1; i++)
                    @(negedge clk);
                @(posedge clk);
                irq <= 1'b0;
            end
        join
        chk(irq_cnt, 40'd1, "irq pulses");
        chk(rep_after, 40'd1, "loop resumes");
        chk(stack_pointer_reg, 16'(va + 16'h0002), "sp push");

        for (int k = 0; k < 2; k++)
        begin
            va = 16'($random(seed)) & 16'h00FF;
            vb = 16'($random(seed)) & 16'h00FF;
            prod = 40'(va) * 40'(vb);
            // Each multiply-accumulate steps both pointers by one word
            prod_b = 40'(va + 16'h0002) * 40'(vb + 16'h0002)
                     + 40'(va + 16'h0004) * 40'(vb + 16'h0004);
            begin_reset();
            prog[0] = mk(dcd_pkg::DCD_OP_MOVI, 4'h6, va);
            prog[1] = mk(dcd_pkg::DCD_OP_MOVI, 4'h7, vb);
            prog[2] = mk(dcd_pkg::DCD_OP_MAC, 4'h0, 16'h6700);
            prog[3] = mk(dcd_pkg::DCD_OP_MAC, 4'h1, 16'h6700);
            prog[4] = mk(dcd_pkg::DCD_OP_MAC, 4'h1, 16'h6700);
            prog[5] = mk(dcd_pkg::DCD_OP_SFTAC, 4'h0, 16'h0010);
            if (k == 1)
            begin
                prog[6] = mk(dcd_pkg::DCD_OP_SFTAC, 4'h0, 16'h0030);
                prog[7] = mk(dcd_pkg::DCD_OP_SFTAC, 4'h0, 16'h0011);
            end
            end_reset();
            watch(20);
            chk(yrd_cnt, 40'd3, "dual fetch strobes");
            chk(acc_b, prod_b, "acc b sum");
            chk(acc_a, (k == 0) ? (prod << 16) : prod, "shifted acc a");
        end

        // Pointer step with modulo wrap, then with reverse-carry sequencing
        for (int k = 0; k < 2; k++)
        begin
            va = 16'($random(seed)) & 16'h7FFE;
            begin_reset();
            mod_end <= va;
            mod_enable <= (k == 0);
            bitrev_enable <= (k == 1);
            prog[0] = mk(dcd_pkg::DCD_OP_MOVI, 4'h6, va);
            prog[1] = mk(dcd_pkg::DCD_OP_MAC, 4'h0, 16'h6700);
            prog[2] = mk(dcd_pkg::DCD_OP_STORE, 4'h6, 16'h6000);
            end_reset();
            watch(10);
            vb = (k == 0) ? mod_start : rev_add(va, bitrev_mod);
            chk(wr_data, vb, "pointer step");
        end
        mod_enable <= 1'b0;
        bitrev_enable <= 1'b0;

        pg = 8'($random(seed));
        va = 16'h8000 | (16'($random(seed)) & 16'h7FFE);
        psv_exp = {pg, va[14:0]};
        begin_reset();
        prog[3] = mk(dcd_pkg::DCD_OP_MOVI, 4'h4, va);
        prog[4] = mk(dcd_pkg::DCD_OP_LOAD, 4'h4, 16'h4000);
        end_reset();
        fork
            watch(14);
            begin
                page_value <= pg;
                page_load <= 1'b1;
                @(posedge clk);
                page_load <= 1'b0;
            end
        join
        chk(psv_hit, 40'd1, "window address");

        test_done();
    end
endmodule
`default_nettype wire
